// File: src/bsx_consts.vh
// Constants for the branch, skip and bit execution unit
// Assumes inclusion by the unit, checker and testbench files
`ifndef BSX_CONSTS_VH
`define BSX_CONSTS_VH
// Register byte addresses
`define BSX_A_CTRL    8'h00
`define BSX_A_INSTR   8'h04
`define BSX_A_PC      8'h08
`define BSX_A_FLAGS   8'h0C
`define BSX_A_REG     8'h10
`define BSX_A_IO      8'h14
`define BSX_A_RESULT  8'h18
`define BSX_A_STATUS  8'h1C
// Instruction operation codes in the instruction register, bits 4:0
`define BSX_OP_SKIP_REG_ONE   5'h00
`define BSX_OP_SKIP_REG_ZERO  5'h01
`define BSX_OP_SKIP_IO_ZERO   5'h02
`define BSX_OP_SKIP_IO_ONE    5'h03
`define BSX_OP_BR_SET         5'h04
`define BSX_OP_BR_CLR         5'h05
`define BSX_OP_BR_SGE         5'h06
`define BSX_OP_BR_SLT         5'h07
`define BSX_OP_IO_SET         5'h08
`define BSX_OP_IO_CLR         5'h09
`define BSX_OP_SHL_ZERO       5'h0A
`define BSX_OP_RL_CARRY       5'h0B
`define BSX_OP_SHR_ZERO       5'h0C
`define BSX_OP_RR_CARRY       5'h0D
`define BSX_OP_SHR_SIGN       5'h0E
`define BSX_OP_T_STORE        5'h0F
`define BSX_OP_T_LOAD         5'h10
`define BSX_OP_FSET           5'h11
`define BSX_OP_FCLR           5'h12
`define BSX_OP_SWAP           5'h13
// Instruction field positions
`define BSX_F_BIT_LO   8
`define BSX_F_SKIP2    11
`define BSX_F_OFS_LO   16
// Status flag bit positions
`define BSX_C  0
`define BSX_Z  1
`define BSX_N  2
`define BSX_V  3
`define BSX_S  4
`define BSX_H  5
`define BSX_T  6
`define BSX_I  7
// Cycle counts
`define BSX_CYC_SHORT  2'h1
`define BSX_CYC_TWO    2'h2
`define BSX_CYC_THREE  2'h3
`endif

// File: src/bsx_unit.v
// Branch, skip, bit and shift execution unit with an AHB-Lite register slave
// Assumes one 100 MHz clock, a single bus master and whole-word transfers
//
// Contract
// RULE1: Skip next instruction when selected general register bit is one; 1/2/3 cycles.
// RULE2: Skip next instruction when selected I/O bit is zero; flags unchanged; 1/2/3 cycles.
// RULE3: Skip next instruction when selected I/O bit is one; flags unchanged; 1/2/3 cycles.
// RULE4: Generic flag branch tests any status bit set or clear; PC+k+1; 1/2 cycles.
// RULE5: Unsigned branches take on carry clear or carry set; 1/2 cycles.
// RULE6: Signed greater-or-equal branches when N xor V is zero; 1 or 2 cycles.
// RULE7: Half-carry branches on H set or clear; 1/2 cycles.
// RULE8: Transfer-flag branches on T set or clear; 1/2 cycles.
// RULE9: Overflow branches on V set or clear; 1/2 cycles.
// RULE10: Interrupt-state branches on I one or zero; 1/2 cycles.
// RULE11: I/O bit set forces one bit to one, others kept, no flags, 2 cycles.
// RULE12: I/O bit clear forces one bit to zero, others kept, no flags, 2 cycles.
// RULE13: Left shifts update Z,C,N,V; rotate takes carry in, logical shift takes zero.
// RULE14: Right shifts update Z,C,N,V; rotate, logical and arithmetic fill bit 7.
// RULE15: Bit store copies selected register bit into T in one cycle.
// RULE16: Bit load copies T into selected register bit, flags unchanged, one cycle.
// RULE17: Signed less-than branches when N xor V is one.
// RULE18: Flag set or clear writes only the named status bit in one cycle.
// RULE19: Nibble swap exchanges register nibbles in one cycle, no flag change.
`timescale 1ns/100ps
`include "bsx_consts.vh"
module bsx_unit #(
	parameter PC_W = 16
) (
	// Clock and reset
	input  wire        CLK_I,
	input  wire        RST_I,
	// AHB-Lite slave
	input  wire        HSEL_I,
	input  wire [31:0] HADDR_I,
	input  wire [1:0]  HTRANS_I,
	input  wire        HWRITE_I,
	input  wire [2:0]  HSIZE_I,
	input  wire [31:0] HWDATA_I,
	input  wire        HREADY_I,
	output reg  [31:0] HRDATA_O,
	output reg         HREADYOUT_O,
	output reg         HRESP_O,
	// Execution status
	output reg         BUSY_O
);
	localparam ST_IDLE = 3'b001;
	localparam ST_EXEC = 3'b010;
	localparam ST_WAIT = 3'b100;

	// Program counter steps: fall through, short skip, long skip
	localparam [PC_W-1:0] PC_STEP1 = {{(PC_W-2){1'b0}}, 2'h1};
	localparam [PC_W-1:0] PC_STEP2 = {{(PC_W-2){1'b0}}, 2'h2};
	localparam [PC_W-1:0] PC_STEP3 = {{(PC_W-2){1'b0}}, 2'h3};

	reg  [31:0]     instr_r;
	reg  [PC_W-1:0] pc_r;
	reg  [7:0]      flags_r;
	reg  [7:0]      gpr_r;
	reg  [7:0]      io_r;
	reg  [7:0]      result_r;
	reg  [1:0]      cycles_r;
	reg             taken_r;
	reg  [1:0]      wait_r;
	reg  [2:0]      state_r;
	reg  [7:0]      dp_addr_r;
	reg             dp_wr_r;
	reg             dp_rd_r;

	// Bit select decode, used for register, I/O and status bits
	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	// Selected bit of a byte, used for register, I/O and status operands
	function pick_bit;
		input [7:0] val;
		input [2:0] idx;
		begin
			pick_bit = |(val & bit_mask(idx));
		end
	endfunction

	// Flags after a shift: C is the bit pushed out, V = N xor C, S = N xor V
	function [7:0] shift_flags;
		input [7:0] old;
		input [7:0] res;
		input       cout;
		begin
			shift_flags         = old;
			shift_flags[`BSX_C] = cout;
			shift_flags[`BSX_Z] = (res == 8'h00);
			shift_flags[`BSX_N] = res[7];
			shift_flags[`BSX_V] = res[7] ^ cout;
			shift_flags[`BSX_S] = res[7] ^ (res[7] ^ cout);
		end
	endfunction

	wire [4:0]      op      = instr_r[4:0];
	wire [2:0]      bsel    = instr_r[`BSX_F_BIT_LO+2:`BSX_F_BIT_LO];
	wire [7:0]      bmask   = bit_mask(bsel);
	wire            skip2   = instr_r[`BSX_F_SKIP2];
	wire [PC_W-1:0] ofs     = {{(PC_W-7){instr_r[`BSX_F_OFS_LO+6]}},
		instr_r[`BSX_F_OFS_LO+6:`BSX_F_OFS_LO]};
	wire            reg_bit = pick_bit(gpr_r, bsel);
	wire            io_bit  = pick_bit(io_r, bsel);
	wire            sr_bit  = pick_bit(flags_r, bsel);
	wire            nxv     = flags_r[`BSX_N] ^ flags_r[`BSX_V];

	// Execution datapath
	reg  [PC_W-1:0] pc_nxt;
	reg  [7:0]      flags_nxt;
	reg  [7:0]      gpr_nxt;
	reg  [7:0]      io_nxt;
	reg  [1:0]      cycles_nxt;
	reg             taken_nxt;
	reg             skip_c;
	reg             br_c;
	reg             shf_c;
	reg  [7:0]      shv;
	reg             shc;
	always @* begin
		pc_nxt     = pc_r + PC_STEP1;
		flags_nxt  = flags_r;
		gpr_nxt    = gpr_r;
		io_nxt     = io_r;
		cycles_nxt = `BSX_CYC_SHORT;
		taken_nxt  = 1'b0;
		skip_c     = 1'b0;
		br_c       = 1'b0;
		shf_c      = 1'b0;
		shv        = gpr_r;
		shc        = flags_r[`BSX_C];
		case (op)
			`BSX_OP_SKIP_REG_ONE:  skip_c = reg_bit; // RULE1
			`BSX_OP_SKIP_REG_ZERO: skip_c = ~reg_bit;
			`BSX_OP_SKIP_IO_ZERO:  skip_c = ~io_bit; // RULE2
			`BSX_OP_SKIP_IO_ONE:   skip_c = io_bit; // RULE3
			// Aliases for Z, N, C, H, T, V, I use the generic forms with their index
			`BSX_OP_BR_SET:        br_c = sr_bit; // RULE4 RULE5 RULE7 RULE8 RULE9 RULE10
			`BSX_OP_BR_CLR:        br_c = ~sr_bit; // RULE4 RULE5 RULE7 RULE8 RULE9 RULE10
			`BSX_OP_BR_SGE:        br_c = ~nxv; // RULE6
			`BSX_OP_BR_SLT:        br_c = nxv; // RULE17
			`BSX_OP_IO_SET: begin
				io_nxt     = io_r | bmask; // RULE11
				cycles_nxt = `BSX_CYC_TWO;
			end
			`BSX_OP_IO_CLR: begin
				io_nxt     = io_r & ~bmask; // RULE12
				cycles_nxt = `BSX_CYC_TWO;
			end
			`BSX_OP_SHL_ZERO: begin
				shf_c = 1'b1;
				shv   = {gpr_r[6:0], 1'b0}; // RULE13
				shc   = gpr_r[7];
			end
			`BSX_OP_RL_CARRY: begin
				shf_c = 1'b1;
				shv   = {gpr_r[6:0], flags_r[`BSX_C]}; // RULE13
				shc   = gpr_r[7];
			end
			`BSX_OP_SHR_ZERO: begin
				shf_c = 1'b1;
				shv   = {1'b0, gpr_r[7:1]}; // RULE14
				shc   = gpr_r[0];
			end
			`BSX_OP_RR_CARRY: begin
				shf_c = 1'b1;
				shv   = {flags_r[`BSX_C], gpr_r[7:1]}; // RULE14
				shc   = gpr_r[0];
			end
			`BSX_OP_SHR_SIGN: begin
				shf_c = 1'b1;
				shv   = {gpr_r[7], gpr_r[7:1]}; // RULE14
				shc   = gpr_r[0];
			end
			`BSX_OP_T_STORE: flags_nxt[`BSX_T] = reg_bit; // RULE15
			`BSX_OP_T_LOAD: begin
				gpr_nxt = flags_r[`BSX_T] ? (gpr_r | bmask) : (gpr_r & ~bmask); // RULE16
			end
			`BSX_OP_FSET: flags_nxt = flags_r | bmask; // RULE18
			`BSX_OP_FCLR: flags_nxt = flags_r & ~bmask; // RULE18
			`BSX_OP_SWAP: gpr_nxt = {gpr_r[3:0], gpr_r[7:4]}; // RULE19
			default: ;
		endcase
		if (shf_c) begin
			gpr_nxt   = shv; // RULE13 RULE14
			flags_nxt = shift_flags(flags_r, shv, shc);
		end
		if (skip_c) begin
			taken_nxt  = 1'b1;
			pc_nxt     = pc_r + (skip2 ? PC_STEP3 : PC_STEP2); // RULE1 RULE2 RULE3
			cycles_nxt = skip2 ? `BSX_CYC_THREE : `BSX_CYC_TWO;
		end
		if (br_c) begin
			taken_nxt  = 1'b1;
			pc_nxt     = pc_r + ofs + PC_STEP1; // RULE4
			cycles_nxt = `BSX_CYC_TWO;
		end
	end

	// Bus address phase capture
	wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dp_addr_r <= 8'h00;
			dp_wr_r   <= 1'b0;
			dp_rd_r   <= 1'b0;
		end else begin
			dp_wr_r <= addr_ok & HWRITE_I;
			dp_rd_r <= addr_ok & ~HWRITE_I;
			if (addr_ok)
				dp_addr_r <= HADDR_I[7:0];
		end
	end

	// Read data, loaded during the address phase so it stands in the data phase
	reg [31:0] rd_mux;
	always @* begin
		case (HADDR_I[7:0])
			`BSX_A_CTRL:   rd_mux = 32'h0000_0000;
			`BSX_A_INSTR:  rd_mux = instr_r;
			`BSX_A_PC:     rd_mux = {{(32-PC_W){1'b0}}, pc_r};
			`BSX_A_FLAGS:  rd_mux = {24'h00_0000, flags_r};
			`BSX_A_REG:    rd_mux = {24'h00_0000, gpr_r};
			`BSX_A_IO:     rd_mux = {24'h00_0000, io_r};
			`BSX_A_RESULT: rd_mux = {24'h00_0000, result_r};
			`BSX_A_STATUS: rd_mux = {28'h000_0000, taken_r, cycles_r, BUSY_O};
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	wire start  = dp_wr_r & (dp_addr_r == `BSX_A_CTRL) & HWDATA_I[0] & (state_r == ST_IDLE);
	wire wr_any = dp_wr_r & (state_r == ST_IDLE);

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HRDATA_O    <= 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
			BUSY_O      <= 1'b0;
			instr_r     <= 32'h0000_0000;
			pc_r        <= {PC_W{1'b0}};
			flags_r     <= 8'h00;
			gpr_r       <= 8'h00;
			io_r        <= 8'h00;
			result_r    <= 8'h00;
			cycles_r    <= 2'h0;
			taken_r     <= 1'b0;
			wait_r      <= 2'h0;
			state_r     <= ST_IDLE;
		end else begin
			HRESP_O     <= 1'b0;
			HREADYOUT_O <= 1'b1;
			if (addr_ok & ~HWRITE_I)
				HRDATA_O <= rd_mux;
			if (wr_any) begin
				case (dp_addr_r)
					`BSX_A_INSTR: instr_r <= HWDATA_I;
					`BSX_A_PC:    pc_r    <= HWDATA_I[PC_W-1:0];
					`BSX_A_FLAGS: flags_r <= HWDATA_I[7:0];
					`BSX_A_REG:   gpr_r   <= HWDATA_I[7:0];
					`BSX_A_IO:    io_r    <= HWDATA_I[7:0];
					default: ;
				endcase
			end
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						BUSY_O  <= 1'b1;
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					pc_r     <= pc_nxt;
					flags_r  <= flags_nxt;
					gpr_r    <= gpr_nxt;
					io_r     <= io_nxt;
					result_r <= gpr_nxt;
					cycles_r <= cycles_nxt;
					taken_r  <= taken_nxt;
					wait_r   <= cycles_nxt - 2'h1;
					if (cycles_nxt == `BSX_CYC_SHORT) begin
						BUSY_O  <= 1'b0;
						state_r <= ST_IDLE;
					end else begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					wait_r <= wait_r - 2'h1;
					if (wait_r == 2'h1) begin
						BUSY_O  <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// File: verif/bsx_chk.sv
// Checker: execution length of each instruction class, seen at the ports
// Assumes bind to bsx_unit, zero wait bus, one clock domain
`timescale 1ns/100ps
`include "bsx_consts.vh"
module bsx_chk (
	// Clock and reset
	input wire        CLK_I,
	input wire        RST_I,
	// Bus and status
	input wire        HSEL_I,
	input wire [31:0] HADDR_I,
	input wire [1:0]  HTRANS_I,
	input wire        HWRITE_I,
	input wire [31:0] HWDATA_I,
	input wire        HREADY_I,
	input wire        BUSY_O
);
	reg       wr_r;
	reg [7:0] adr_r;
	reg [4:0] op_r;
	reg       two_r;
	wire      go;
	assign go = wr_r && HREADY_I && adr_r == `BSX_A_CTRL && HWDATA_I[0] && !BUSY_O;
	// Track the last instruction word written
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_r <= 1'b0;
			adr_r <= 8'h00;
			op_r <= 5'h00;
			two_r <= 1'b0;
		end else if (HREADY_I) begin
			wr_r <= HSEL_I & HTRANS_I[1] & HWRITE_I;
			adr_r <= HADDR_I[7:0];
			if (wr_r && adr_r == `BSX_A_INSTR) begin
				op_r <= HWDATA_I[4:0];
				two_r <= HWDATA_I[`BSX_F_SKIP2];
			end
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	sequence one_s; BUSY_O ##1 !BUSY_O; endsequence
	sequence two_s; BUSY_O [*2] ##1 !BUSY_O; endsequence
	sequence upto_s; BUSY_O ##[1:2] !BUSY_O; endsequence
	a_busy_bound: assert property ($rose(BUSY_O) |-> ##[1:3] !BUSY_O)
		else $error("busy too long");
	a_skip_long: assert property (go && op_r < 5'h04 && two_r |=> BUSY_O ##[1:3] !BUSY_O)
		else $error("long skip length");
	a_skip_short: assert property (go && op_r < 5'h04 && !two_r |=> upto_s)
		else $error("short skip length");
	a_branch_len: assert property (go && op_r inside {[5'h04:5'h07]} |=> upto_s)
		else $error("branch length");
	a_io_set: assert property (go && op_r == `BSX_OP_IO_SET |=> two_s)
		else $error("io set length");
	a_io_clr: assert property (go && op_r == `BSX_OP_IO_CLR |=> two_s)
		else $error("io clear length");
	a_shift_one: assert property (go && op_r inside {[5'h0A:5'h0E]} |=> one_s)
		else $error("shift length");
	a_tbit_one: assert property (go && op_r inside {5'h0F, 5'h10} |=> one_s)
		else $error("bit copy length");
	a_flag_one: assert property (go && op_r inside {[5'h11:5'h13]} |=> one_s)
		else $error("flag or swap length");
endmodule
bind bsx_unit bsx_chk u_bsx_chk (.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
	.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
	.HREADY_I(HREADY_I), .BUSY_O(BUSY_O));

// File: verif/bsx_unit_tb_top.sv
// Testbench: runs each instruction class through the register bus
// Assumes a zero wait slave that always answers OKAY
`timescale 1ns/100ps
`include "bsx_consts.vh"
`define CK(a, m, e) begin \
	xf(1'b0, a, 32'h0); \
	checked++; \
	if ({rsp, q & (m)} !== {1'b0, (e)}) begin \
		fail_count++; \
		$display("ERROR t=%0t a=%h got %h exp %h", $time, a, q & (m), e); \
	end \
end
module bsx_unit_tb_top;
	reg        clk = 0;
	reg        rst = 1;
	reg        hsel = 0;
	reg        hw = 0;
	reg [1:0]  ht = 0;
	reg [31:0] ha = 0;
	reg [31:0] hd = 0;
	reg [31:0] q;
	reg        rsp;
	wire [31:0] hr;
	wire       hro;
	wire       busy;
	wire       hresp;
	int        fail_count = 0;
	int        checked = 0;
	always #5 clk = ~clk;
	bsx_unit u_bsx_unit (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(ha), .HTRANS_I(ht),
		.HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hd), .HREADY_I(hro), .HRDATA_O(hr),
		.HREADYOUT_O(hro), .HRESP_O(hresp), .BUSY_O(busy));
	task close_out;
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task wt;
		int n;
		n = 0;
		@(posedge clk);
		while (hro !== 1'b1) begin
			if (++n > 20) begin
				fail_count++;
				close_out;
			end
			@(posedge clk);
		end
	endtask
	task xf(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		hw <= w;
		ha <= {24'h0, a};
		ht <= 2'h2;
		wt;
		hsel <= 1'b0;
		ht <= 2'h0;
		hd <= d;
		wt;
		q = hr;
		rsp = hresp;
	endtask
	task run(input [31:0] ins, input [7:0] sr, rg, io, input [15:0] pc);
		int n;
		xf(1'b1, `BSX_A_PC, {16'h0, pc});
		xf(1'b1, `BSX_A_FLAGS, {24'h0, sr});
		xf(1'b1, `BSX_A_REG, {24'h0, rg});
		xf(1'b1, `BSX_A_IO, {24'h0, io});
		xf(1'b1, `BSX_A_INSTR, ins);
		xf(1'b1, `BSX_A_CTRL, 32'h1);
		n = 0;
		q = 32'h1;
		while (q[0] !== 1'b0) begin
			if (++n > 20) begin
				fail_count++;
				close_out;
			end
			xf(1'b0, `BSX_A_STATUS, 32'h0);
		end
	endtask
	function [15:0] sx(input [4:0] o, input [7:0] r, input c);
		reg [7:0] y;
		reg       co;
		case (o)
			`BSX_OP_SHL_ZERO: {co, y} = {r, 1'b0};
			`BSX_OP_RL_CARRY: {co, y} = {r, c};
			`BSX_OP_SHR_ZERO: {y, co} = {1'b0, r};
			`BSX_OP_RR_CARRY: {y, co} = {c, r};
			default: {y, co} = {r[7], r};
		endcase
		sx = {y, 3'b111, co, y[7] ^ co, y[7], y == 8'h00, co};
	endfunction
	task t_skip;
		run(32'h0A00, 8'h00, 8'h04, 8'h00, 16'h0010);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h0013)
		`CK(`BSX_A_STATUS, 32'hF, 32'hE)
		run(32'h0201, 8'h00, 8'hFB, 8'h00, 16'h0010);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h0012)
		`CK(`BSX_A_STATUS, 32'hF, 32'hC)
		run(32'h0502, 8'hFF, 8'h00, 8'hDF, 16'h0010);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h0012)
		`CK(`BSX_A_FLAGS, 32'hFF, 32'hFF)
		run(32'h0503, 8'h00, 8'h00, 8'h20, 16'h0010);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h0012)
		run(32'h0503, 8'h00, 8'h00, 8'hDF, 16'h0010);
		`CK(`BSX_A_STATUS, 32'hF, 32'h2)
		$display("skip test done");
	endtask
	task t_branch;
		for (int i = 0; i < 8; i++) begin
			run({9'h0, 7'h7D, 5'h0, i[2:0], 8'h04}, 8'h01 << i, 8'h00, 8'h00, 16'h0100);
			`CK(`BSX_A_PC, 32'hFFFF, 32'h00FE)
			`CK(`BSX_A_STATUS, 32'hF, 32'hC)
			run({9'h0, 7'h7D, 5'h0, i[2:0], 8'h05}, 8'h01 << i, 8'h00, 8'h00, 16'h0100);
			`CK(`BSX_A_PC, 32'hFFFF, 32'h0101)
		end
		run(32'h0040_0006, 8'h04, 8'h00, 8'h00, 16'h0100);
		`CK(`BSX_A_STATUS, 32'hF, 32'h2)
		run(32'h0040_0007, 8'h04, 8'h00, 8'h00, 16'h0100);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h00C1)
		run(32'h003F_0006, 8'h0C, 8'h00, 8'h00, 16'h0100);
		`CK(`BSX_A_PC, 32'hFFFF, 32'h0140)
		$display("branch test done");
	endtask
	task t_io;
		run(32'h0108, 8'h5A, 8'h00, 8'hA5, 16'h0000);
		xf(1'b1, 8'h24, 32'h0);
		`CK(`BSX_A_IO, 32'hFF, 32'hA7)
		`CK(`BSX_A_FLAGS, 32'hFF, 32'h5A)
		`CK(`BSX_A_STATUS, 32'h6, 32'h4)
		run(32'h0709, 8'h5A, 8'h00, 8'hA5, 16'h0000);
		`CK(`BSX_A_IO, 32'hFF, 32'h25)
		`CK(`BSX_A_STATUS, 32'h6, 32'h4)
		$display("io bit test done");
	endtask
	task t_shift;
		reg [15:0] e;
		for (int o = 10; o < 15; o++) begin
			for (int j = 0; j < 2; j++) begin
				e = sx(o[4:0], 8'h81 - j[7:0], j[0]);
				run({27'h0, o[4:0]}, {7'h70, j[0]}, 8'h81 - j[7:0], 8'h00, 16'h0000);
				`CK(`BSX_A_RESULT, 32'hFF, {24'h0, e[15:8]})
				`CK(`BSX_A_FLAGS, 32'hFF, {24'h0, e[7:0]})
			end
		end
		$display("shift test done");
	endtask
	task t_bits;
		run(32'h030F, 8'h00, 8'h08, 8'h00, 16'h0000);
		`CK(`BSX_A_FLAGS, 32'hFF, 32'h40)
		run(32'h0010, 8'h40, 8'h00, 8'h00, 16'h0000);
		`CK(`BSX_A_RESULT, 32'hFF, 32'h01)
		`CK(`BSX_A_FLAGS, 32'hFF, 32'h40)
		run(32'h0013, 8'hA5, 8'h3C, 8'h00, 16'h0000);
		`CK(`BSX_A_RESULT, 32'hFF, 32'hC3)
		`CK(`BSX_A_FLAGS, 32'hFF, 32'hA5)
		for (int i = 0; i < 8; i++) begin
			run({21'h0, i[2:0], 8'h11}, 8'h00, 8'h00, 8'h00, 16'h0000);
			`CK(`BSX_A_FLAGS, 32'hFF, 32'h1 << i)
			run({21'h0, i[2:0], 8'h12}, 8'hFF, 8'h00, 8'h00, 16'h0000);
			`CK(`BSX_A_FLAGS, 32'hFF, 32'hFF ^ (32'h1 << i))
		end
		$display("bit test done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_skip;
		t_branch;
		t_io;
		t_shift;
		t_bits;
		close_out;
	end
endmodule
